// ---- rbad_pkg.sv ----
/*
 * Shared constants for the RGBA block alpha decoder: block layout, alpha
 * header field positions, the register map and the modifier tables.
 * Assumes a 32-bit AXI4-Lite register bus and byte addresses of 8 bits.
 */
package rbad_pkg;

    // ------------------------------------------------------------
    // Block layout
    // ------------------------------------------------------------
    localparam int BLK_BITS = 128;
    localparam int WORD_BITS = 64;
    localparam int WORD_BYTES = 8;
    localparam int PIX_N = 16;
    localparam int IDX_BITS = 3;
    localparam int HDR_BITS = 16;
    localparam int BASE_HI = 63;
    localparam int BASE_LO = 56;
    localparam int MULT_HI = 55;
    localparam int MULT_LO = 52;
    localparam int TSEL_HI = 51;
    localparam int TSEL_LO = 48;
    localparam int IDX_TOP = 47;
    localparam logic [3:0] MULT_ZERO = 4'h0;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_BLKCNT = 8'h08;
    localparam logic [7:0] OFF_HDR = 8'h0C;
    localparam logic [7:0] OFF_ALPHA0 = 8'h10;
    localparam logic [7:0] OFF_STEP = 8'h04;
    localparam int ALPHA_REGS = 4;
    localparam int CTRL_EN_BIT = 0;
    localparam int STAT_ZM_BIT = 0;
    localparam int STAT_OV_BIT = 1;
    localparam int STAT_IR_BIT = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Modifier tables, four negative then four non-negative entries
    // ------------------------------------------------------------
    localparam logic signed [4:0] MOD_TAB [PIX_N][8] = '{
        '{-5'sh3, -5'sh6, -5'sh9, -5'shF, 5'sh2, 5'sh5, 5'sh8, 5'shE},
        '{-5'sh3, -5'sh7, -5'shA, -5'shD, 5'sh2, 5'sh6, 5'sh9, 5'shC},
        '{-5'sh2, -5'sh5, -5'sh8, -5'shD, 5'sh1, 5'sh4, 5'sh7, 5'shC},
        '{-5'sh2, -5'sh4, -5'sh6, -5'shD, 5'sh1, 5'sh3, 5'sh5, 5'shC},
        '{-5'sh3, -5'sh6, -5'sh8, -5'shC, 5'sh2, 5'sh5, 5'sh7, 5'shB},
        '{-5'sh3, -5'sh7, -5'sh9, -5'shB, 5'sh2, 5'sh6, 5'sh8, 5'shA},
        '{-5'sh4, -5'sh7, -5'sh8, -5'shB, 5'sh3, 5'sh6, 5'sh7, 5'shA},
        '{-5'sh3, -5'sh5, -5'sh8, -5'shB, 5'sh2, 5'sh4, 5'sh7, 5'shA},
        '{-5'sh2, -5'sh6, -5'sh8, -5'shA, 5'sh1, 5'sh5, 5'sh7, 5'sh9},
        '{-5'sh2, -5'sh5, -5'sh8, -5'shA, 5'sh1, 5'sh4, 5'sh7, 5'sh9},
        '{-5'sh2, -5'sh4, -5'sh8, -5'shA, 5'sh1, 5'sh3, 5'sh7, 5'sh9},
        '{-5'sh2, -5'sh5, -5'sh7, -5'shA, 5'sh1, 5'sh4, 5'sh6, 5'sh9},
        '{-5'sh3, -5'sh4, -5'sh7, -5'shA, 5'sh2, 5'sh3, 5'sh6, 5'sh9},
        '{-5'sh1, -5'sh2, -5'sh3, -5'shA, 5'sh0, 5'sh1, 5'sh2, 5'sh9},
        '{-5'sh4, -5'sh6, -5'sh8, -5'sh9, 5'sh3, 5'sh5, 5'sh7, 5'sh8},
        '{-5'sh3, -5'sh5, -5'sh7, -5'sh9, 5'sh2, 5'sh4, 5'sh6, 5'sh8}
    };
    localparam logic signed [10:0] BYTE_MIN = 11'sh000;
    localparam logic signed [10:0] BYTE_MAX = 11'sh0FF;

endpackage

// ---- rbad_byte_pack.sv ----
/*
 * Assembles one 64-bit word from eight bytes in memory order.
 * Byte k (lowest address at k = 0) sits at bits 8k+7:8k of the input.
 */
`timescale 1ns/100ps
`default_nettype none

module rbad_byte_pack (
    input wire logic [63:0] bytes_in,
    output logic [63:0] word_out
);

    // ------------------------------------------------------------
    // Big-endian assembly
    // ------------------------------------------------------------
    for (genvar k = 0; k < rbad_pkg::WORD_BYTES; k++) begin : g_byte
        assign word_out[rbad_pkg::WORD_BITS - 1 - 8 * k -: 8] = bytes_in[8 * k +: 8];
    end

endmodule
`default_nettype wire

// ---- rbad_alpha_pixel.sv ----
/*
 * Alpha value of one texel from the block header and its 3-bit index.
 * Purely combinational; the caller registers the result.
 */
`timescale 1ns/100ps
`default_nettype none

module rbad_alpha_pixel (
    input wire logic [7:0] base,
    input wire logic [3:0] mult,
    input wire logic [3:0] tsel,
    input wire logic [2:0] idx,
    output logic [7:0] alpha
);

    logic signed [4:0] modifier;
    logic signed [9:0] product;
    logic signed [10:0] sum;

    // ------------------------------------------------------------
    // Saturation
    // ------------------------------------------------------------
    function automatic logic [7:0] saturate_to_byte(input logic signed [10:0] v);
        if (v < rbad_pkg::BYTE_MIN) begin
            return 8'h00;
        end else if (v > rbad_pkg::BYTE_MAX) begin
            return 8'hFF;
        end
        return v[7:0];
    endfunction

    // ------------------------------------------------------------
    // Datapath
    // ------------------------------------------------------------
    always_comb begin
        modifier = rbad_pkg::MOD_TAB[tsel][idx];
        product = 10'(modifier) * $signed({6'h00, mult});
        sum = $signed({3'h0, base}) + 11'(product);
        alpha = saturate_to_byte(sum);
    end

endmodule
`default_nettype wire

// ---- rbad_decoder.sv ----
/*
 * RGBA block alpha decoder: takes 128-bit compressed blocks from the
 * texture fetch stage, decodes sixteen alpha values and forwards the color
 * word to the RGB block path. One register stage, AXI4-Lite control.
 * Assumes one clock, synchronous active-low reset, a single AXI master.
 */
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module rbad_decoder (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [127:0] in_bytes,
    input wire logic in_srgb,
    output logic out_valid,
    input wire logic out_ready,
    output logic [127:0] out_alpha,
    output logic [63:0] out_color_word,
    output logic out_srgb
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic out_valid;
        logic [127:0] out_alpha;
        logic [63:0] out_color;
        logic out_srgb;
        logic ctrl_en;
        logic zero_mult_seen;
        logic [31:0] blk_count;
        logic [15:0] last_hdr;
        logic aw_got;
        logic [7:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } rbad_state_t;

    localparam rbad_state_t ST_RST = '{ctrl_en: 1'b1, default: '0};

    rbad_state_t st_r;
    rbad_state_t st_nxt;

    logic [63:0] alpha_word;
    logic [63:0] color_word;
    logic [7:0] base;
    logic [3:0] mult;
    logic [3:0] tsel;
    logic [127:0] pix_alpha;
    logic take_blk;
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic wr_fire;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
        return addr[7:2] == off[7:2];
    endfunction

    function automatic logic reg_mapped(input logic [7:0] addr);
        logic hit;
        hit = reg_hit(addr, rbad_pkg::OFF_CTRL) || reg_hit(addr, rbad_pkg::OFF_STATUS);
        hit = hit || reg_hit(addr, rbad_pkg::OFF_BLKCNT) || reg_hit(addr, rbad_pkg::OFF_HDR);
        for (int i = 0; i < rbad_pkg::ALPHA_REGS; i++) begin
            hit = hit || reg_hit(addr, 8'(rbad_pkg::OFF_ALPHA0 + 8'(i) * rbad_pkg::OFF_STEP));
        end
        return hit;
    endfunction

    // ------------------------------------------------------------
    // Block split and word assembly
    // ------------------------------------------------------------
    // alpha bytes first in memory
    rbad_byte_pack u_pack_alpha (
        .bytes_in(in_bytes[63:0]),
        .word_out(alpha_word)
    );

    // color word in same byte order
    rbad_byte_pack u_pack_color (
        .bytes_in(in_bytes[127:64]),
        .word_out(color_word)
    );

    // ------------------------------------------------------------
    // Header fields
    // ------------------------------------------------------------
    // base from top byte
    assign base = alpha_word[rbad_pkg::BASE_HI:rbad_pkg::BASE_LO];
    assign mult = alpha_word[rbad_pkg::MULT_HI:rbad_pkg::MULT_LO];
    assign tsel = alpha_word[rbad_pkg::TSEL_HI:rbad_pkg::TSEL_LO];

    // ------------------------------------------------------------
    // Per-pixel decode
    // ------------------------------------------------------------
    // Sixteen parallel lanes: costs area, keeps one block per clock.
    for (genvar p = 0; p < rbad_pkg::PIX_N; p++) begin : g_pix
        rbad_alpha_pixel u_pix (
            .base(base),
            .mult(mult),
            .tsel(tsel),
            .idx(alpha_word[rbad_pkg::IDX_TOP - rbad_pkg::IDX_BITS * p -: rbad_pkg::IDX_BITS]),
            .alpha(pix_alpha[8 * p +: 8])
        );
    end

    // ------------------------------------------------------------
    // Stream handshake
    // ------------------------------------------------------------
    // New block enters when enabled and the output stage is empty or drains in the same cycle
    assign in_ready = st_r.ctrl_en && (!st_r.out_valid || out_ready);
    assign take_blk = in_valid && in_ready;

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------
    assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
    assign s_axi_wready = !st_r.w_got && !st_r.bvalid;
    assign s_axi_arready = !st_r.rvalid;
    assign aw_hs = s_axi_awvalid && s_axi_awready;
    assign w_hs = s_axi_wvalid && s_axi_wready;
    assign ar_hs = s_axi_arvalid && s_axi_arready;
    assign wr_fire = (st_r.aw_got || aw_hs) && (st_r.w_got || w_hs) && !st_r.bvalid;
    assign wr_addr = st_r.aw_got ? st_r.awaddr : s_axi_awaddr;
    assign wr_data = st_r.w_got ? st_r.wdata : s_axi_wdata;
    assign wr_strb = st_r.w_got ? st_r.wstrb : s_axi_wstrb;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic zm_clr;
        logic cnt_clr;
        zm_clr = 1'b0;
        cnt_clr = 1'b0;
        st_nxt = st_r;

        // Output register
        if (st_r.out_valid && out_ready) begin
            st_nxt.out_valid = 1'b0;
        end
        if (take_blk) begin
            st_nxt.out_valid = 1'b1;
            st_nxt.out_alpha = pix_alpha;
            st_nxt.out_color = color_word;
            st_nxt.out_srgb = in_srgb;
            st_nxt.last_hdr = alpha_word[rbad_pkg::BASE_HI -: rbad_pkg::HDR_BITS];
        end

        // Write channel capture
        if (aw_hs) begin
            st_nxt.aw_got = 1'b1;
            st_nxt.awaddr = s_axi_awaddr;
        end
        if (w_hs) begin
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = s_axi_wdata;
            st_nxt.wstrb = s_axi_wstrb;
        end

        // Register write
        if (wr_fire) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = reg_mapped(wr_addr) ? rbad_pkg::RESP_OKAY : rbad_pkg::RESP_SLVERR;
            if (reg_hit(wr_addr, rbad_pkg::OFF_CTRL) && wr_strb[0]) begin
                st_nxt.ctrl_en = wr_data[rbad_pkg::CTRL_EN_BIT];
            end
            if (reg_hit(wr_addr, rbad_pkg::OFF_STATUS) && wr_strb[0]) begin
                zm_clr = wr_data[rbad_pkg::STAT_ZM_BIT];
            end
            if (reg_hit(wr_addr, rbad_pkg::OFF_BLKCNT)) begin
                cnt_clr = 1'b1;
            end
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end

        // Sticky flag and counter: a new block wins over a clear
        // zero multiplier flagged, still decoded
        st_nxt.zero_mult_seen = (st_r.zero_mult_seen && !zm_clr) || (take_blk && mult == rbad_pkg::MULT_ZERO);
        if (cnt_clr) begin
            st_nxt.blk_count = take_blk ? 32'h0000_0001 : 32'h0000_0000;
        end else if (take_blk) begin
            st_nxt.blk_count = st_r.blk_count + 32'h0000_0001;
        end

        // Register read
        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (ar_hs) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = reg_mapped(s_axi_araddr) ? rbad_pkg::RESP_OKAY : rbad_pkg::RESP_SLVERR;
            st_nxt.rdata = 32'h0000_0000;
            if (reg_hit(s_axi_araddr, rbad_pkg::OFF_CTRL)) begin
                st_nxt.rdata[rbad_pkg::CTRL_EN_BIT] = st_r.ctrl_en;
            end
            if (reg_hit(s_axi_araddr, rbad_pkg::OFF_STATUS)) begin
                st_nxt.rdata[rbad_pkg::STAT_ZM_BIT] = st_r.zero_mult_seen;
                st_nxt.rdata[rbad_pkg::STAT_OV_BIT] = st_r.out_valid;
                st_nxt.rdata[rbad_pkg::STAT_IR_BIT] = in_ready;
            end
            if (reg_hit(s_axi_araddr, rbad_pkg::OFF_BLKCNT)) begin
                st_nxt.rdata = st_r.blk_count;
            end
            if (reg_hit(s_axi_araddr, rbad_pkg::OFF_HDR)) begin
                st_nxt.rdata[rbad_pkg::HDR_BITS - 1:0] = st_r.last_hdr;
            end
            for (int i = 0; i < rbad_pkg::ALPHA_REGS; i++) begin
                if (reg_hit(s_axi_araddr, 8'(rbad_pkg::OFF_ALPHA0 + 8'(i) * rbad_pkg::OFF_STEP))) begin
                    st_nxt.rdata = st_r.out_alpha[32 * i +: 32];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;
    assign out_valid = st_r.out_valid;
    assign out_alpha = st_r.out_alpha;
    assign out_color_word = st_r.out_color;
    assign out_srgb = st_r.out_srgb;

endmodule
`default_nettype wire

// ---- rbad_decoder_properties.sv ----
/* Concurrent checks on the stream ports of the alpha decoder top.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/100ps
`default_nettype none
module rbad_decoder_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic in_valid,
    input wire logic in_ready,
    input wire logic [127:0] in_bytes,
    input wire logic in_srgb,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic [127:0] out_alpha,
    input wire logic [63:0] out_color_word,
    input wire logic out_srgb
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    logic [63:0] aw_c;
    logic [63:0] cw_c;
    logic [7:0] base_c;
    wire logic take = in_valid && in_ready;
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            aw_c[63-8*k -: 8] = in_bytes[8*k +: 8];
            cw_c[63-8*k -: 8] = in_bytes[64+8*k +: 8];
        end
        base_c = aw_c[63:56];
    end
    default clocking dc @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_alpha)
        && $stable(out_color_word)) else $error("output moved while stalled");
    full_refuse_a: assert property (out_valid && !out_ready |-> !in_ready)
        else $error("block taken while output full");
    take_out_a: assert property (take |=> out_valid) else $error("no output after block");
    color_pass_a: assert property (take |=> out_color_word == $past(cw_c))
        else $error("color word altered");
    srgb_same_a: assert property (take |=> out_srgb == $past(in_srgb)) else $error("srgb flag lost");
    zero_mult_a: assert property (take && aw_c[55:52] == 4'h0 |=> out_alpha == {16{$past(base_c)}})
        else $error("zero multiplier not base");
    table_pick_a: assert property (take && aw_c[51:48] == 4'hD && aw_c[47:45] == 3'h4
        |=> out_alpha[7:0] == $past(base_c)) else $error("pixel a wrong entry");
    second_pix_a: assert property (take && aw_c[51:48] == 4'hD && aw_c[44:42] == 3'h4
        |=> out_alpha[15:8] == $past(base_c)) else $error("pixel b wrong entry");
    clamp_top_a: assert property (take && base_c == 8'hFF && aw_c[47] |=> out_alpha[7:0] == 8'hFF)
        else $error("high clamp missed");
    clamp_low_a: assert property (take && base_c == 8'h00 && !aw_c[47] |=> out_alpha[7:0] == 8'h00)
        else $error("low clamp missed");
endmodule
bind rbad_decoder rbad_decoder_checker rbad_decoder_checker_i (.aclk, .aresetn, .in_valid, .in_ready,
    .in_bytes, .in_srgb, .out_valid, .out_ready, .out_alpha, .out_color_word, .out_srgb);
`default_nettype wire

// ---- rbad_fetch_model.sv ----
/* Behavioural texture fetch stage: offers queued blocks, takes texels.
   Assumes the bench queues blocks through the push task. */
`timescale 1ns/100ps
`default_nettype none
module rbad_fetch_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic stall,
    input wire logic in_ready,
    output logic in_valid,
    output logic [127:0] in_bytes,
    output logic in_srgb,
    output logic out_ready
);
    // ------------------------------------------------------------
    // Source and sink
    // ------------------------------------------------------------
    logic [128:0] q[$];
    logic [1:0] cnt;
    initial begin
        in_valid = 1'b0;
        in_bytes = 128'h0;
        in_srgb = 1'b0;
        out_ready = 1'b1;
        cnt = 2'h0;
    end
    task automatic push(input logic [128:0] v);
        q.push_back(v);
    endtask
    always @(posedge aclk) begin
        cnt <= cnt + 2'h1;
        // Slow sink takes one cycle in four
        out_ready <= !stall || (cnt == 2'h0);
        if (!aresetn) begin
            in_valid <= 1'b0;
        end else if (!in_valid || in_ready) begin
            if (q.size() > 0) begin
                {in_srgb, in_bytes} <= q.pop_front();
                in_valid <= 1'b1;
            end else begin
                // Idle bus never repeats a stale block
                in_valid <= 1'b0;
                in_bytes <= ~in_bytes;
            end
        end
    end
endmodule
`default_nettype wire

// ---- test_rbad_decoder.sv ----
/* Self-checking bench for the alpha decoder with random and corner blocks.
   Assumes the fetch model and the bound checker of this folder. */
`timescale 1ns/100ps
`default_nettype none
module test_rbad_decoder;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic aclk = 1'b0, aresetn = 1'b0, stall = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic in_valid, in_ready, in_srgb, out_valid, out_ready, out_srgb;
    logic [127:0] in_bytes, out_alpha, last_a;
    logic [63:0] out_color_word;
    logic [127:0] exp_a[$];
    logic [64:0] exp_c[$];
    int n_errors = 0, num_checks = 0, cyc = 0;
    int tab[128] = '{-3, -6, -9, -15, 2, 5, 8, 14, -3, -7, -10, -13, 2, 6, 9, 12,
        -2, -5, -8, -13, 1, 4, 7, 12, -2, -4, -6, -13, 1, 3, 5, 12, -3, -6, -8, -12, 2, 5, 7, 11,
        -3, -7, -9, -11, 2, 6, 8, 10, -4, -7, -8, -11, 3, 6, 7, 10, -3, -5, -8, -11, 2, 4, 7, 10,
        -2, -6, -8, -10, 1, 5, 7, 9, -2, -5, -8, -10, 1, 4, 7, 9, -2, -4, -8, -10, 1, 3, 7, 9,
        -2, -5, -7, -10, 1, 4, 6, 9, -3, -4, -7, -10, 2, 3, 6, 9, -1, -2, -3, -10, 0, 1, 2, 9,
        -4, -6, -8, -9, 3, 5, 7, 8, -3, -5, -7, -9, 2, 4, 6, 8};
    always #5 aclk = ~aclk;
    rbad_decoder rbad_decoder_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .in_valid, .in_ready, .in_bytes,
        .in_srgb, .out_valid, .out_ready, .out_alpha, .out_color_word, .out_srgb);
    rbad_fetch_model fetch_i (.aclk, .aresetn, .stall, .in_ready, .in_valid, .in_bytes, .in_srgb,
        .out_ready);
    // ------------------------------------------------------------
    // Expectations and checks
    // ------------------------------------------------------------
    function automatic logic [127:0] exp_alpha(input logic [63:0] aw);
        logic [127:0] res;
        int v;
        for (int p = 0; p < 16; p++) begin
            v = int'(aw[63:56]) + tab[aw[51:48] * 8 + aw[47-3*p -: 3]] * int'(aw[55:52]);
            res[8*p +: 8] = v < 0 ? 8'h00 : (v > 255 ? 8'hFF : v[7:0]);
        end
        return res;
    endfunction
    task automatic chk_d(input string nm, input logic [127:0] e, input logic [127:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_w(input string nm, input logic [33:0] e, input logic [33:0] g);
        chk_d(nm, 128'(e), 128'(g));
    endtask
    task automatic send(input logic [63:0] aw, input logic [63:0] cw, input logic s);
        logic [127:0] b;
        for (int k = 0; k < 8; k++) begin
            b[8*k +: 8] = aw[63-8*k -: 8];
            b[64+8*k +: 8] = cw[63-8*k -: 8];
        end
        fetch_i.push({s, b});
        last_a = exp_alpha(aw);
        exp_a.push_back(last_a);
        exp_c.push_back({s, cw});
    endtask
    always @(posedge aclk) begin
        if (aresetn && out_valid && out_ready) begin
            chk_w("spare", 34'h1, 34'(exp_a.size() > 0));
            chk_d("alpha", exp_a.pop_front(), out_alpha);
            chk_d("color", 128'(exp_c.pop_front()), {63'h0, out_srgb, out_color_word});
        end
    end
    task automatic rd(input logic [7:0] a, output logic [33:0] v);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        v = {s_axi_rresp, s_axi_rdata};
        s_axi_rready <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] dv, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= dv;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic chkr(input string nm, input logic [7:0] a, input logic [33:0] e);
        logic [33:0] v;
        rd(a, v);
        chk_w(nm, e, v);
    endtask
    task automatic drain();
        int n;
        n = 0;
        while (exp_a.size() > 0 && n < 3000) begin
            @(posedge aclk);
            n++;
        end
        chk_w("drained", 34'h0, 34'(exp_a.size()));
        repeat (2) @(posedge aclk);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Hang guard, far above the expected run
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            close_out();
        end
    end
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        logic [1:0] r;
        logic [63:0] aw;
        void'($urandom(32'h0bdc));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        chkr("ctrl", rbad_pkg::OFF_CTRL, {rbad_pkg::RESP_OKAY, 32'h00000001});
        chkr("status", rbad_pkg::OFF_STATUS, {rbad_pkg::RESP_OKAY, 32'h00000004});
        chkr("unmapped", 8'h40, {rbad_pkg::RESP_SLVERR, 32'h00000000});
        wr(8'h40, 32'h0000FFFF, r);
        chk_w("wresp", {rbad_pkg::RESP_SLVERR, 32'h0}, {r, 32'h0});
        wr(rbad_pkg::OFF_CTRL, 32'h0, r);
        chk_w("wresp ok", {rbad_pkg::RESP_OKAY, 32'h0}, {r, 32'h0});
        send({8'h67, 4'h2, 4'hD, 3'h3, 3'h4, 42'h0}, 64'h0123456789ABCDEF, 1'b1);
        repeat (6) @(posedge aclk);
        chk_w("stalled", 34'h1, 34'(exp_a.size()));
        wr(rbad_pkg::OFF_CTRL, 32'h1, r);
        drain();
        $display("test registers and enable done");
        for (int m = 1; m < 16; m += 14) begin
            for (int t = 0; t < 16; t++) begin
                aw = {8'h80, 4'(m), 4'(t), 48'h0};
                // Index offset moves two entries of each table, (m + t) mod 8 for m = 1 and 15, under pixel a
                for (int p = 0; p < 16; p++) aw[47-3*p -: 3] = 3'(p + m + t);
                send(aw, {$urandom(), $urandom()}, 1'(t));
            end
        end
        send({8'hFF, 4'hF, 4'h0, 48'hFFFFFFFFFFFF}, 64'h0, 1'b0);
        send({8'h00, 4'hF, 4'h0, 48'h0}, 64'hFFFFFFFFFFFFFFFF, 1'b1);
        send({8'h5A, 4'h0, 4'h7, 48'({$urandom(), $urandom()})}, 64'h0, 1'b0);
        drain();
        chkr("zero seen", rbad_pkg::OFF_STATUS, {rbad_pkg::RESP_OKAY, 32'h00000005});
        wr(rbad_pkg::OFF_STATUS, 32'h1, r);
        chkr("zero cleared", rbad_pkg::OFF_STATUS, {rbad_pkg::RESP_OKAY, 32'h00000004});
        $display("test tables and corners done");
        wr(rbad_pkg::OFF_BLKCNT, 32'h0, r);
        stall <= 1'b1;
        for (int i = 0; i < 200; i++) begin
            aw = {$urandom(), $urandom()};
            if (aw[55:52] == 4'h0) aw[55:52] = 4'h1;
            send(aw, {$urandom(), $urandom()}, 1'($urandom()));
        end
        drain();
        stall <= 1'b0;
        chkr("blkcnt", rbad_pkg::OFF_BLKCNT, {rbad_pkg::RESP_OKAY, 32'h000000C8});
        chkr("header", rbad_pkg::OFF_HDR, {rbad_pkg::RESP_OKAY, 16'h0, aw[63:48]});
        for (int i = 0; i < 4; i++) begin
            chkr("alpha reg", 8'(rbad_pkg::OFF_ALPHA0 + rbad_pkg::OFF_STEP * i),
                {rbad_pkg::RESP_OKAY, last_a[32*i +: 32]});
        end
        $display("test random stream done");
        close_out();
    end
endmodule
`default_nettype wire
